// [iacu_top.v]
// Purpose: executes i/o and accumulator commands written over ahb-lite
// Assumes: single clock hclk, asynchronous active-low hresetn
// Notes: zero-wait slave; a command runs one cycle after its checksum write
//
// Local design decisions: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "iacu_map.vh"
module iacu_top (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  // digital and analog inputs
  input wire gp_input_a,
  input wire gp_input_b,
  input wire shutdown_in,
  input wire enc_near_zero,
  input wire [11:0] adc_a,
  input wire [11:0] adc_b,
  input wire [15:0] supply_dv,
  input wire [15:0] temp_c,
  // outputs
  output reg gp_output_a,
  output reg gp_output_b,
  output reg pullup_stop_l_en,
  output reg pullup_stop_r_en,
  output reg pullup_home_en
);

  // -----------------------------------------
  // helpers
  // -----------------------------------------
  // byte sum of one word, modulo 256
  function [7:0] csum4;
    input [31:0] w;
    begin
      csum4 = w[31:24] + w[23:16] + w[15:8] + w[7:0];
    end
  endfunction

  // -----------------------------------------
  // state
  // -----------------------------------------
  reg wr_pend_r;
  reg [7:0] wa_r;
  reg go_r;
  reg [31:0] cmd_hdr_r;
  reg [31:0] cmd_val_r;
  reg [7:0] cmd_sum_r;
  reg standalone_r;
  reg [7:0] mod_addr_r;
  reg [7:0] host_addr_r;
  reg [31:0] rpl_hdr_r;
  reg [31:0] rpl_val_r;
  reg [7:0] rpl_sum_r;
  reg rpl_valid_r;
  reg [31:0] acc_r;
  reg [2:0] flags_r;
  reg [7:0] gpo_r;
  reg [2:0] pullup_r;

  // command fields
  wire [7:0] c_target = cmd_hdr_r[31:24];
  wire [7:0] c_instr = cmd_hdr_r[23:16];
  wire [7:0] c_type = cmd_hdr_r[15:8];
  wire [7:0] c_bank = cmd_hdr_r[7:0];

  // -----------------------------------------
  // sub-blocks
  // -----------------------------------------
  wire [31:0] alu_res;
  wire alu_ok;
  wire f_eq;
  wire f_gt;
  wire f_lt;
  wire [31:0] in_val;
  wire in_ok;

  iacu_alu u_alu (
    .op(c_type),
    .acc(acc_r),
    .opnd(cmd_val_r),
    .res(alu_res),
    .ok(alu_ok),
    .flag_eq(f_eq),
    .flag_gt(f_gt),
    .flag_lt(f_lt)
  );

  iacu_in_sel u_in (
    .bank(c_bank),
    .port(c_type),
    .gp_input_a(gp_input_a),
    .gp_input_b(gp_input_b),
    .shutdown_in(shutdown_in),
    .enc_near_zero(enc_near_zero),
    .adc_a(adc_a),
    .adc_b(adc_b),
    .supply_dv(supply_dv),
    .temp_c(temp_c),
    .gpo(gpo_r),
    .val(in_val),
    .ok(in_ok)
  );

  // -----------------------------------------
  // command execution
  // -----------------------------------------
  reg [7:0] st_nxt;
  reg [31:0] rv_nxt;
  reg [31:0] acc_nxt;
  reg [2:0] flags_nxt;
  reg [7:0] gpo_nxt;
  reg [2:0] pullup_nxt;
  wire sum_ok = (csum4(cmd_hdr_r) + csum4(cmd_val_r)) == cmd_sum_r;
  wire val_bit = (cmd_val_r[31:1] == 31'h0000_0000);

  always @* begin
    st_nxt = `IACU_ST_OK;
    rv_nxt = 32'h0000_0000;
    acc_nxt = acc_r;
    flags_nxt = flags_r;
    gpo_nxt = gpo_r;
    pullup_nxt = pullup_r;
    if (!sum_ok) begin
      st_nxt = `IACU_ST_BAD_SUM;
    end else if (c_instr == `IACU_I_SET_OUT) begin
      if (c_bank == `IACU_BANK_2 && (c_type == `IACU_PORT_A || c_type == `IACU_PORT_B)) begin
        if (val_bit) gpo_nxt[c_type[0]] = cmd_val_r[0];
        else st_nxt = `IACU_ST_BAD_VAL;
      end else if (c_bank == `IACU_BANK_2 && c_type == `IACU_PORT_ALL) begin
        if (cmd_val_r == `IACU_VAL_FROM_ACC) gpo_nxt = acc_r[7:0];
        else if (cmd_val_r[31:8] == 24'h00_0000) gpo_nxt = cmd_val_r[7:0];
        else st_nxt = `IACU_ST_BAD_VAL;
      end else if (c_bank == `IACU_BANK_0 && c_type == `IACU_PORT_A) begin
        pullup_nxt = cmd_val_r[2:0];
      end else begin
        st_nxt = `IACU_ST_BAD_TYPE;
      end
    end else if (c_instr == `IACU_I_GET_IN) begin
      if (in_ok) begin
        rv_nxt = in_val;
        if (standalone_r) acc_nxt = in_val;
        else if (c_bank == `IACU_BANK_0 && c_type == `IACU_PORT_ALL) acc_nxt = {acc_r[31:8], in_val[7:0]};
      end else begin
        st_nxt = `IACU_ST_BAD_TYPE;
      end
    end else if (c_instr == `IACU_I_ACC_OP) begin
      if (alu_ok) begin
        acc_nxt = alu_res;
        rv_nxt = cmd_val_r;
      end else begin
        st_nxt = (c_type > `IACU_OP_LOAD) ? `IACU_ST_BAD_TYPE : `IACU_ST_BAD_VAL;
      end
    end else if (c_instr == `IACU_I_COMPARE) begin
      flags_nxt = {f_lt, f_gt, f_eq};
      rv_nxt = cmd_val_r;
    end else begin
      st_nxt = `IACU_ST_BAD_CMD;
    end
  end

  // reply frame words and their checksum
  wire [31:0] rh_nxt = {host_addr_r, mod_addr_r, st_nxt, c_instr};
  wire [7:0] rs_nxt = csum4(rh_nxt) + csum4(rv_nxt);
  wire run = go_r && (c_target == mod_addr_r);
  wire good = run && (st_nxt == `IACU_ST_OK);

  // -----------------------------------------
  // ahb-lite address and data phase
  // -----------------------------------------
  wire take = hsel && hready && htrans[1];
  wire wr_sum = wr_pend_r && (wa_r == `IACU_A_CMD_SUM);
  reg [31:0] rd_nxt;

  // read mux, sampled in the address phase
  always @* begin
    rd_nxt = 32'h0000_0000;
    if (haddr[7:0] == `IACU_A_CMD_HDR) rd_nxt = cmd_hdr_r;
    else if (haddr[7:0] == `IACU_A_CMD_VAL) rd_nxt = cmd_val_r;
    else if (haddr[7:0] == `IACU_A_CMD_SUM) rd_nxt = {24'h00_0000, cmd_sum_r};
    else if (haddr[7:0] == `IACU_A_CTRL) rd_nxt = {8'h00, host_addr_r, mod_addr_r, 7'h00, standalone_r};
    else if (haddr[7:0] == `IACU_A_RPL_HDR) rd_nxt = rpl_hdr_r;
    else if (haddr[7:0] == `IACU_A_RPL_VAL) rd_nxt = rpl_val_r;
    else if (haddr[7:0] == `IACU_A_RPL_SUM) rd_nxt = {23'h00_0000, rpl_valid_r, rpl_sum_r};
    else if (haddr[7:0] == `IACU_A_ACCUM) rd_nxt = acc_r;
    else if (haddr[7:0] == `IACU_A_STATE) rd_nxt = {13'h0000, pullup_r, gpo_r, 5'h00, flags_r};
  end

  // bus slave flops; response is always okay with no wait
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      wr_pend_r <= 1'b0;
      wa_r <= 8'h00;
      go_r <= 1'b0;
    end else begin
      wr_pend_r <= take && hwrite;
      if (take) wa_r <= haddr[7:0];
      if (take && !hwrite) hrdata <= rd_nxt;
      go_r <= wr_sum;
    end
  end

  // -----------------------------------------
  // software-written registers
  // -----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_hdr_r <= 32'h0000_0000;
      cmd_val_r <= 32'h0000_0000;
      cmd_sum_r <= 8'h00;
      standalone_r <= 1'b0;
      mod_addr_r <= `IACU_MOD_ADDR_RST;
      host_addr_r <= `IACU_HOST_ADDR_RST;
    end else if (wr_pend_r) begin
      if (wa_r == `IACU_A_CMD_HDR) cmd_hdr_r <= hwdata;
      else if (wa_r == `IACU_A_CMD_VAL) cmd_val_r <= hwdata;
      else if (wa_r == `IACU_A_CMD_SUM) cmd_sum_r <= hwdata[7:0];
      else if (wa_r == `IACU_A_CTRL) begin
        standalone_r <= hwdata[`IACU_CTRL_STANDALONE];
        mod_addr_r <= hwdata[15:8];
        host_addr_r <= hwdata[23:16];
      end
    end
  end

  // -----------------------------------------
  // execution results
  // -----------------------------------------
  // a new checksum write clears the reply flag; a finished command sets it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rpl_hdr_r <= 32'h0000_0000;
      rpl_val_r <= 32'h0000_0000;
      rpl_sum_r <= 8'h00;
      rpl_valid_r <= 1'b0;
      acc_r <= 32'h0000_0000;
      flags_r <= 3'h0;
      gpo_r <= 8'h00;
      pullup_r <= `IACU_PULLUP_RST;
    end else begin
      if (run) begin
        rpl_hdr_r <= rh_nxt;
        rpl_val_r <= rv_nxt;
        rpl_sum_r <= rs_nxt;
        rpl_valid_r <= 1'b1;
      end else if (wr_sum) begin
        rpl_valid_r <= 1'b0;
      end
      if (good) begin
        acc_r <= acc_nxt;
        flags_r <= flags_nxt;
        gpo_r <= gpo_nxt;
        pullup_r <= pullup_nxt;
      end
    end
  end

  // -----------------------------------------
  // pin outputs, one flop stage after the state
  // -----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gp_output_a <= 1'b0;
      gp_output_b <= 1'b0;
      pullup_stop_l_en <= 1'b1;
      pullup_stop_r_en <= 1'b1;
      pullup_home_en <= 1'b1;
    end else begin
      gp_output_a <= gpo_r[0];
      gp_output_b <= gpo_r[1];
      pullup_stop_l_en <= pullup_r[0];
      pullup_stop_r_en <= pullup_r[1];
      pullup_home_en <= pullup_r[2];
    end
  end

endmodule

// [iacu_map.vh]
// Purpose: constants for the i/o and accumulator command unit
// Assumes: 32-bit ahb-lite register bus, byte addresses in haddr[7:0]
// Notes: included by every design file of the block
//
// Operation
// - set-output to bank 2, port 0 or 1, drives that output line to 0/1
// - set-output port 255 bank 2 loads all outputs from low eight value bits
// - set-output port 255 bank 2 with value -1 takes the bits from the accumulator
// - set-output port 0 bank 0 programs pull-ups: bit0 left, bit1 right, bit2 home
// - a set bit enables a pull-up, clear disables; all enabled after reset
// - get-input returns 0/1 for digital lines, 0..4095 for analog channels
// - standalone get-input loads the accumulator; direct mode leaves it alone except port 255 bank 0
// - get-input is instruction 15, banks 0..2, replies status 100 with value
// - get-input port 255 bank 0 puts the two general-purpose inputs (not shutdown or encoder-near-zero) in accumulator low bits
// - bank 0 port 10 returns shutdown input, port 11 encoder-near-zero
// - bank 0 ports 0 and 1 return digital states of the two inputs
// - bank 1 ports 0/1 analog, port 8 supply in 0.1 V, port 9 temperature
// - get-input bank 2 port 0 or 1 returns the output state as last set
// - calculate is instruction 19, combines accumulator with operand into accumulator
// - calculate types 0..9: add sub mul div mod and or xor invert load
// - direct-mode calculate replies status 100 echoing the operand
// - compare is instruction 20, sets arithmetic flags from accumulator vs operand
`ifndef IACU_MAP_VH
`define IACU_MAP_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define IACU_A_CMD_HDR 8'h00
`define IACU_A_CMD_VAL 8'h04
`define IACU_A_CMD_SUM 8'h08
`define IACU_A_CTRL 8'h0C
`define IACU_A_RPL_HDR 8'h10
`define IACU_A_RPL_VAL 8'h14
`define IACU_A_RPL_SUM 8'h18
`define IACU_A_ACCUM 8'h1C
`define IACU_A_STATE 8'h20
// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define IACU_CTRL_STANDALONE 0
`define IACU_RPL_VALID 8
`define IACU_MOD_ADDR_RST 8'h01
`define IACU_HOST_ADDR_RST 8'h02
`define IACU_PULLUP_RST 3'h7
// ----------------------------------------------------------------
// instructions, status codes, banks, ports
// ----------------------------------------------------------------
`define IACU_I_SET_OUT 8'h0E
`define IACU_I_GET_IN 8'h0F
`define IACU_I_ACC_OP 8'h13
`define IACU_I_COMPARE 8'h14
`define IACU_ST_OK 8'h64
`define IACU_ST_BAD_SUM 8'h01
`define IACU_ST_BAD_CMD 8'h02
`define IACU_ST_BAD_TYPE 8'h03
`define IACU_ST_BAD_VAL 8'h04
`define IACU_BANK_0 8'h00
`define IACU_BANK_1 8'h01
`define IACU_BANK_2 8'h02
`define IACU_PORT_A 8'h00
`define IACU_PORT_B 8'h01
`define IACU_PORT_VSUP 8'h08
`define IACU_PORT_TEMP 8'h09
`define IACU_PORT_SHDN 8'h0A
`define IACU_PORT_ENC0 8'h0B
`define IACU_PORT_ALL 8'hFF
`define IACU_VAL_FROM_ACC 32'hFFFF_FFFF
// ----------------------------------------------------------------
// accumulator operations
// ----------------------------------------------------------------
`define IACU_OP_ADD 8'h00
`define IACU_OP_SUB 8'h01
`define IACU_OP_MUL 8'h02
`define IACU_OP_DIV 8'h03
`define IACU_OP_REM 8'h04
`define IACU_OP_AND 8'h05
`define IACU_OP_OR 8'h06
`define IACU_OP_XOR 8'h07
`define IACU_OP_INV 8'h08
`define IACU_OP_LOAD 8'h09
`endif

// [iacu_alu.v]
// Purpose: accumulator arithmetic and compare for the command unit
// Assumes: signed 32-bit two's-complement operands
// Notes: purely combinational; divide or remainder by zero is refused
`timescale 1ns/1ps
`include "iacu_map.vh"
module iacu_alu (
  // operation select and operands
  input wire [7:0] op,
  input wire signed [31:0] acc,
  input wire signed [31:0] opnd,
  // result
  output reg signed [31:0] res,
  output reg ok,
  // compare flags
  output wire flag_eq,
  output wire flag_gt,
  output wire flag_lt
);

  // -----------------------------------------
  // operation select
  // -----------------------------------------
  // results wrap at 32 bits like the accumulator itself
  always @* begin
    ok = 1'b1;
    res = acc;
    case (op)
      `IACU_OP_ADD: res = acc + opnd;
      `IACU_OP_SUB: res = acc - opnd;
      `IACU_OP_MUL: res = acc * opnd;
      `IACU_OP_DIV: begin
        if (opnd == 32'sh0000_0000) ok = 1'b0;
        else res = acc / opnd;
      end
      `IACU_OP_REM: begin
        if (opnd == 32'sh0000_0000) ok = 1'b0;
        else res = acc % opnd;
      end
      `IACU_OP_AND: res = acc & opnd;
      `IACU_OP_OR: res = acc | opnd;
      `IACU_OP_XOR: res = acc ^ opnd;
      `IACU_OP_INV: res = ~acc;
      `IACU_OP_LOAD: res = opnd;
      default: ok = 1'b0;
    endcase
  end

  // -----------------------------------------
  // signed compare of accumulator against operand
  // -----------------------------------------
  assign flag_eq = (acc == opnd);
  assign flag_gt = (acc > opnd);
  assign flag_lt = (acc < opnd);

endmodule

// [iacu_in_sel.v]
// Purpose: port selection for the get-input command
// Assumes: pin inputs are synchronous to hclk
// Notes: combinational; ok low for an unknown bank/port pair
`timescale 1ns/1ps
`include "iacu_map.vh"
module iacu_in_sel (
  // address
  input wire [7:0] bank,
  input wire [7:0] port,
  // digital inputs
  input wire gp_input_a,
  input wire gp_input_b,
  input wire shutdown_in,
  input wire enc_near_zero,
  // analog values
  input wire [11:0] adc_a,
  input wire [11:0] adc_b,
  input wire [15:0] supply_dv,
  input wire [15:0] temp_c,
  // output states
  input wire [7:0] gpo,
  // result
  output reg [31:0] val,
  output reg ok
);

  // -----------------------------------------
  // bank and port decode
  // -----------------------------------------
  always @* begin
    ok = 1'b1;
    val = 32'h0000_0000;
    if (bank == `IACU_BANK_0) begin
      if (port == `IACU_PORT_A) val[0] = gp_input_a;
      else if (port == `IACU_PORT_B) val[0] = gp_input_b;
      else if (port == `IACU_PORT_ALL) val[1:0] = {gp_input_b, gp_input_a};
      else if (port == `IACU_PORT_SHDN) val[0] = shutdown_in;
      else if (port == `IACU_PORT_ENC0) val[0] = enc_near_zero;
      else ok = 1'b0;
    end else if (bank == `IACU_BANK_1) begin
      if (port == `IACU_PORT_A) val[11:0] = adc_a;
      else if (port == `IACU_PORT_B) val[11:0] = adc_b;
      else if (port == `IACU_PORT_VSUP) val[15:0] = supply_dv;
      else if (port == `IACU_PORT_TEMP) val = {{16{temp_c[15]}}, temp_c};
      else ok = 1'b0;
    end else if (bank == `IACU_BANK_2) begin
      if (port == `IACU_PORT_A) val[0] = gpo[0];
      else if (port == `IACU_PORT_B) val[0] = gpo[1];
      else ok = 1'b0;
    end else begin
      ok = 1'b0;
    end
  end

endmodule

// [iacu_chk_monitor.sv]
// Purpose: bus and pin checker for the i/o and accumulator command unit
// Assumes: sees only the top module ports, zero-wait slave
// Notes: attached to every iacu_top by the bind at the foot
`timescale 1ns/1ps
module iacu_chk (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  // pins
  input wire gp_output_a,
  input wire gp_output_b,
  input wire pullup_stop_l_en,
  input wire pullup_stop_r_en,
  input wire pullup_home_en
);
  // ----------------------------------------------------------------
  // transfer decode and recent checksum-write history
  // ----------------------------------------------------------------
  logic take;
  logic rd_take;
  logic sum_take;
  logic [5:0] sh_r;
  assign take = hsel & hready & htrans[1];
  assign rd_take = take & ~hwrite;
  assign sum_take = take & hwrite & (haddr[7:0] == 8'h08);
  // pins may only move a few cycles after a command starts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) sh_r <= 6'h00;
    else sh_r <= {sh_r[4:0], sum_take};
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_READY: assert property (hreadyout) else $error("slave inserted a wait state");
  AST_RESP: assert property (!hresp) else $error("slave answered with an error");
  AST_RST_OUT: assert property ($rose(hresetn) |-> !gp_output_a && !gp_output_b)
    else $error("outputs not low after reset");
  AST_RST_PULL: assert property ($rose(hresetn) |-> pullup_stop_l_en && pullup_stop_r_en && pullup_home_en)
    else $error("pull-ups not on after reset");
  AST_OUT_CAUSE: assert property ($changed({gp_output_a, gp_output_b}) |-> |sh_r)
    else $error("output moved without a command");
  AST_PULL_CAUSE: assert property ($changed({pullup_stop_l_en, pullup_stop_r_en, pullup_home_en}) |-> |sh_r)
    else $error("pull-up moved without a command");
  AST_HOLD: assert property (!$past(rd_take) |-> $stable(hrdata)) else $error("read data moved");
  AST_UNMAPPED: assert property (rd_take && haddr[7:0] > 8'h20 |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_SUM_FMT: assert property (rd_take && haddr[7:0] == 8'h18 |=> hrdata[31:9] == 23'h00_0000)
    else $error("reply checksum word has stray bits");
  AST_FLAGS: assert property (rd_take && haddr[7:0] == 8'h20 |=> $onehot0(hrdata[2:0]))
    else $error("more than one compare flag set");
  AST_STATUS: assert property (rd_take && haddr[7:0] == 8'h10 |=> hrdata[15:8] inside {8'h00, 8'h64,
    8'h01, 8'h02, 8'h03, 8'h04}) else $error("unknown reply status");
endmodule
bind iacu_top iacu_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .gp_output_a(gp_output_a), .gp_output_b(gp_output_b), .pullup_stop_l_en(pullup_stop_l_en),
  .pullup_stop_r_en(pullup_stop_r_en), .pullup_home_en(pullup_home_en));

// [iacu_host.sv]
// Purpose: host side model that issues register transfers
// Assumes: single whole-word transfers, one slave
// Notes: each phase is held until hready is seen high at a rising edge
`timescale 1ns/1ps
module iacu_host (
  // clock and bus answer
  input wire hclk,
  input wire hready,
  input wire [31:0] hrdata,
  // bus request
  output reg hsel,
  output reg [31:0] haddr,
  output reg [1:0] htrans,
  output reg hwrite,
  output reg [2:0] hsize,
  output reg [31:0] hwdata
);
  // idle bus from time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end
  // one transfer: address phase, then data phase, read data taken at its end
  task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] q);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      q = hrdata;
      hwdata <= ~d;
    end
  endtask
endmodule

// [io_accumulator_command_unit_bench.sv]
// Purpose: self-checking bench for the i/o and accumulator command unit
// Assumes: reset addresses (host 2, module 1), commands framed through registers
// Notes: a behavioural model of accumulator, outputs and flags predicts every reply
`timescale 1ns/1ps
`include "iacu_map.vh"
module io_accumulator_command_unit_bench;
  // ----------------------------------------------------------------
  // signals and model state
  // ----------------------------------------------------------------
  localparam [143:0] PORT_TAB = {16'h0000, 16'h0001, 16'h000A, 16'h000B, 16'h00FF, 16'h0100, 16'h0101,
    16'h0108, 16'h0109};
  reg hclk, hresetn, ia, ib, sd, ez, sa;
  reg [11:0] aa, ab;
  reg [15:0] sv, tc, bp;
  reg [7:0] outs;
  reg [2:0] pu, fl;
  reg [31:0] rd, r1;
  wire hsel, hwrite, hreadyout, hresp, oa, ob, pl, pr, ph;
  wire [31:0] haddr, hwdata, hrdata;
  wire [1:0] htrans;
  wire [2:0] hsize;
  integer n_mismatch, num_checks, seed, acc, i, j, v;
  iacu_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .gp_input_a(ia), .gp_input_b(ib), .shutdown_in(sd), .enc_near_zero(ez), .adc_a(aa), .adc_b(ab),
    .supply_dv(sv), .temp_c(tc), .gp_output_a(oa), .gp_output_b(ob), .pullup_stop_l_en(pl),
    .pullup_stop_r_en(pr), .pullup_home_en(ph));
  iacu_host host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  // clock of 50 ns
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // ----------------------------------------------------------------
  // compare, commands and model
  // ----------------------------------------------------------------
  task chk(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // frame one command, then read back reply, accumulator, state and pins
  task cmd(input [7:0] ins, input [7:0] ty, input [7:0] bk, input [31:0] val, input [7:0] st, input [31:0] ev);
    reg [7:0] s;
    begin
      s = 8'h01 + ins + ty + bk + val[31:24] + val[23:16] + val[15:8] + val[7:0];
      host.xfer(1'b1, `IACU_A_CMD_HDR, {8'h01, ins, ty, bk}, rd);
      host.xfer(1'b1, `IACU_A_CMD_VAL, val, rd);
      host.xfer(1'b1, `IACU_A_CMD_SUM, {24'h00_0000, s + (st == `IACU_ST_BAD_SUM)}, rd);
      host.xfer(1'b0, `IACU_A_RPL_HDR, 32'h0000_0000, rd);
      chk(rd, {8'h02, 8'h01, st, ins});
      if (st == `IACU_ST_OK) begin
        s = 8'h03 + st + ins + ev[31:24] + ev[23:16] + ev[15:8] + ev[7:0];
        host.xfer(1'b0, `IACU_A_RPL_VAL, 32'h0000_0000, rd);
        chk(rd, ev);
        host.xfer(1'b0, `IACU_A_RPL_SUM, 32'h0000_0000, rd);
        chk(rd, {23'h00_0000, 1'b1, s});
      end
      host.xfer(1'b0, `IACU_A_ACCUM, 32'h0000_0000, rd);
      chk(rd, acc);
      host.xfer(1'b0, `IACU_A_STATE, 32'h0000_0000, rd);
      chk(rd, {13'h0000, pu, outs, 5'h00, fl});
      chk({oa, ob, pl, pr, ph}, {outs[0], outs[1], pu[0], pu[1], pu[2]});
    end
  endtask
  // expected port reading for a bank and port pair
  function [31:0] inval(input [15:0] p);
    case (p)
      16'h0000: inval = ia;
      16'h0001: inval = ib;
      16'h000A: inval = sd;
      16'h000B: inval = ez;
      16'h00FF: inval = {ib, ia};
      16'h0100: inval = aa;
      16'h0101: inval = ab;
      16'h0108: inval = sv;
      default: inval = {{16{tc[15]}}, tc};
    endcase
  endfunction
  // closing report
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // hang guard of 20000 cycles
  initial begin
    #1_000_000;
    n_mismatch = n_mismatch + 1;
    print_verdict;
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    seed = 44751;
    {n_mismatch, num_checks, acc} = 96'h0;
    {ia, ib, sd, ez, aa, ab, sv, tc, sa, fl, outs} = 72'h0;
    pu = 3'h7;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({oa, ob, pl, pr, ph}, 32'h0000_0007);
    host.xfer(1'b0, `IACU_A_STATE, 32'h0000_0000, rd);
    chk(rd, 32'h0007_0000);
    host.xfer(1'b0, 8'h3C, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0000);
    for (i = 0; i < 4; i = i + 1) begin
      outs[i[0]] = !i[1];
      cmd(`IACU_I_SET_OUT, i[0], `IACU_BANK_2, !i[1], `IACU_ST_OK, 0);
      cmd(`IACU_I_GET_IN, i[0], `IACU_BANK_2, 0, `IACU_ST_OK, outs[i[0]]);
    end
    for (i = 0; i < 8; i = i + 1) begin
      pu = i;
      cmd(`IACU_I_SET_OUT, `IACU_PORT_A, `IACU_BANK_0, i, `IACU_ST_OK, 0);
    end
    for (j = 0; j < 36; j = j + 1) begin
      if (j == 18) begin
        host.xfer(1'b1, `IACU_A_CTRL, 32'h0002_0101, rd);
        sa = 1'b1;
        host.xfer(1'b0, `IACU_A_CTRL, 32'h0000_0000, rd);
        chk(rd, 32'h0002_0101);
      end
      if (j % 9 == 0) begin
        @(posedge hclk);
        r1 = $random(seed);
        {ia, ib, sd, ez, aa, ab} <= r1[27:0];
        r1 = $random(seed);
        {sv, tc} <= r1;
        // let the new pin values land before the model reads them
        @(posedge hclk);
      end
      bp = PORT_TAB[(j % 9) * 16 +: 16];
      v = inval(bp);
      if (sa)
        acc = v;
      else if (bp == 16'h00FF)
        acc[7:0] = v[7:0];
      cmd(`IACU_I_GET_IN, bp[7:0], bp[15:8], 0, `IACU_ST_OK, v);
    end
    for (i = 0; i < 20; i = i + 1) begin
      v = $random(seed) | 1;
      case (i % 10)
        0: acc = acc + v;
        1: acc = acc - v;
        2: acc = acc * v;
        3: acc = acc / v;
        4: acc = acc % v;
        5: acc = acc & v;
        6: acc = acc | v;
        7: acc = acc ^ v;
        8: acc = ~acc;
        default: acc = v;
      endcase
      cmd(`IACU_I_ACC_OP, i % 10, 8'h00, v, `IACU_ST_OK, v);
    end
    outs = acc[7:0];
    cmd(`IACU_I_SET_OUT, `IACU_PORT_ALL, `IACU_BANK_2, `IACU_VAL_FROM_ACC, `IACU_ST_OK, 0);
    v = $random(seed) & 255;
    outs = v;
    cmd(`IACU_I_SET_OUT, `IACU_PORT_ALL, `IACU_BANK_2, v, `IACU_ST_OK, 0);
    for (i = 0; i < 3; i = i + 1) begin
      v = acc + i - 1;
      fl = {acc < v, acc > v, acc == v};
      cmd(`IACU_I_COMPARE, 8'h00, 8'h00, v, `IACU_ST_OK, v);
    end
    cmd(`IACU_I_COMPARE, 8'h00, 8'h00, 5, `IACU_ST_BAD_SUM, 0);
    // refused commands leave accumulator, flags, outputs and pull-ups alone
    cmd(8'h2A, 8'h00, 8'h00, 0, `IACU_ST_BAD_CMD, 0);
    cmd(`IACU_I_ACC_OP, `IACU_OP_DIV, 8'h00, 0, `IACU_ST_BAD_VAL, 0);
    cmd(`IACU_I_ACC_OP, 8'h0C, 8'h00, 1, `IACU_ST_BAD_TYPE, 0);
    cmd(`IACU_I_SET_OUT, `IACU_PORT_A, `IACU_BANK_2, 2, `IACU_ST_BAD_VAL, 0);
    cmd(`IACU_I_GET_IN, `IACU_PORT_A, 8'h03, 0, `IACU_ST_BAD_TYPE, 0);
    // a frame for another module address gets no reply and clears reply-valid
    host.xfer(1'b1, `IACU_A_CMD_HDR, 32'h0514_0000, rd);
    host.xfer(1'b1, `IACU_A_CMD_SUM, 32'h0000_0019, rd);
    host.xfer(1'b0, `IACU_A_RPL_SUM, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0015);
    print_verdict;
  end
endmodule
